// *** ebi_params.svh ***
/*
 * Constants of the external bus pin interface.
 * Assumes inclusion before the package and the top module.
 */
`ifndef EBI_PARAMS_SVH
`define EBI_PARAMS_SVH

`define EBI_ADDR_W      24
`define EBI_DATA_W      16
`define EBI_AREAS       8
`define EBI_AREA_MSB    23
`define EBI_AREA_LSB    21
`define EBI_DRAM_AREA   3'h3
`define EBI_ADDR_RST    24'h00_0000
`define EBI_DATA_RST    16'h0000
`define EBI_AREA_IDLE   8'hff

`endif

// *** ebi_pkg.sv ***
/*
 * Types of the external bus pin interface: request, pin set, state.
 * Assumes ebi_params.svh is on the include path.
 */
`default_nettype none
`include "ebi_params.svh"

package ebi_pkg;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_ADDR,
		ST_STROBE,
		ST_REF_CAS,
		ST_REF_RAS,
		ST_FINISH,
		ST_HELD
	} bus_state_e;

	typedef struct packed {
		logic                     write;
		logic                     upper;
		logic                     lower;
		logic [`EBI_ADDR_W-1:0]   addr;
		logic [`EBI_DATA_W-1:0]   wdata;
	} bus_req_s;

	typedef struct packed {
		logic [`EBI_ADDR_W-1:0]   addr;
		logic [`EBI_AREAS-1:0]    area_n;
		logic                     addr_strobe_n;
		logic                     rd_n;
		logic                     upper_write_n;
		logic                     lower_write_n;
		logic                     refresh_cycle_n;
		logic                     grant_n;
		logic                     bus_oe_b;
		logic                     data_oe_b;
		logic [`EBI_DATA_W-1:0]   dout;
	} bus_pins_s;

	typedef struct packed {
		bus_state_e               state;
		bus_req_s                 req;
		bus_pins_s                pins;
		logic [`EBI_DATA_W-1:0]   rdata;
		logic                     ready;
		logic                     done;
		logic                     ref_ack;
	} bus_core_s;

endpackage

`default_nettype wire

// *** ebi_pin_if.sv ***
/*
 * External bus pin interface: masters address, data and strobes,
 * handles wait, hold request/grant, and DRAM on area 3.
 * Assumes all inputs synchronous to core_clk_i; pad logic joins the
 * separate in/out/enable signals of each pin.
 */
`default_nettype none
`include "ebi_params.svh"

// Functional notes
// R1 - the 24-line address output carries the address of every external access.
// R2 - the 16-line data bus is driven by us on writes and by the addressed party on reads.
// R3 - of eight active-low area selects only the one of the accessed area goes low.
// R4 - the address strobe is low while the address lines hold a valid address.
// R5 - the read strobe is low during cycles that read external space.
// R6 - the upper write strobe is low on writes whose bits 15 to 8 carry valid data.
// R7 - the lower write strobe is low on writes whose bits 7 to 0 carry valid data.
// R8 - an external party may hold the wait input low to stretch the access with wait states.
// R9 - an external master asks for the bus by pulling the hold request input low.
// R10 - the grant output goes low once the bus has been handed over.
// R11 - the refresh indicator is low during DRAM refresh cycles.
// R12 - with DRAM on area 3 the area 3 select is the row address strobe.
// R13 - with dual write-enable DRAM the read strobe is the single column strobe.
// R14 - with dual column-strobe DRAM the read strobe is the write enable.
// R15 - the upper write strobe is upper write enable or upper column strobe by DRAM type.
// R16 - the lower write strobe is lower write enable or lower column strobe by DRAM type.
// R17 - a running cycle ends before the grant, and all bus outputs float while granted.

module ebi_pin_if (
	input  wire logic                    core_clk_i,           // 10 MHz core clock
	input  wire logic                    rst_b_i,              // async reset, active low
	input  wire logic                    req_valid_i,          // access request
	input  wire ebi_pkg::bus_req_s       req_i,                // access details
	input  wire logic                    refresh_req_i,        // refresh wanted
	input  wire logic                    dram_area3_i,         // DRAM fitted on area 3
	input  wire logic                    dual_cas_i,           // 1: two CAS, 0: two WE
	output logic                         ready_o,              // may take a request
	output logic                         done_o,               // access finished pulse
	output logic [`EBI_DATA_W-1:0]       rdata_o,              // read data
	output logic                         ref_ack_o,            // refresh finished pulse
	output logic [`EBI_ADDR_W-1:0]       addr_o,               // address pins
	output logic [`EBI_DATA_W-1:0]       data_o,               // data pins, out
	output logic                         data_oe_b_o,          // data enable, low drives
	input  wire logic [`EBI_DATA_W-1:0]  data_i,               // data pins, in
	output logic [`EBI_AREAS-1:0]        area_sel_n_o,         // area selects
	output logic                         addr_strobe_n_o,      // address strobe
	output logic                         read_n_o,             // read / CAS / WE
	output logic                         upper_write_n_o,      // upper write, enable or column strobe
	output logic                         lower_write_n_o,      // lower write, enable or column strobe
	output logic                         bus_oe_b_o,           // addr+strobe enable, low drives
	input  wire logic                    wait_n_i,             // wait request
	input  wire logic                    bus_hold_request_n_i, // external master asks
	output logic                         bus_grant_n_o,        // bus handed over
	output logic                         refresh_cycle_n_o     // refresh in progress
);

	ebi_pkg::bus_core_s s;
	ebi_pkg::bus_core_s next_s;
	logic [2:0]         next_area;
	logic               next_dram;

	always_comb begin
		next_s         = s;
		next_s.done    = 1'b0;
		next_s.ref_ack = 1'b0;
		case (s.state)
			ebi_pkg::ST_IDLE: begin
				if (!bus_hold_request_n_i) begin
					next_s.state = ebi_pkg::ST_HELD; // R9 R17
				end else if (refresh_req_i && dram_area3_i) begin
					next_s.state = ebi_pkg::ST_REF_CAS;
				end else if (req_valid_i) begin
					next_s.state = ebi_pkg::ST_ADDR;
					next_s.req   = req_i;
				end
			end
			ebi_pkg::ST_ADDR: begin
				next_s.state = ebi_pkg::ST_STROBE;
			end
			ebi_pkg::ST_STROBE: begin
				// stay while wait is low
				if (wait_n_i) begin // R8
					next_s.state = ebi_pkg::ST_FINISH;
					next_s.done  = 1'b1;
					if (!s.req.write) begin
						next_s.rdata = data_i; // R2
					end
				end
			end
			ebi_pkg::ST_REF_CAS: begin
				next_s.state = ebi_pkg::ST_REF_RAS;
			end
			ebi_pkg::ST_REF_RAS: begin
				next_s.state   = ebi_pkg::ST_FINISH;
				next_s.ref_ack = 1'b1;
			end
			ebi_pkg::ST_FINISH: begin
				next_s.state = ebi_pkg::ST_IDLE;
			end
			ebi_pkg::ST_HELD: begin
				if (bus_hold_request_n_i) begin
					next_s.state = ebi_pkg::ST_IDLE;
				end
			end
			default: begin
				next_s.state = ebi_pkg::ST_IDLE;
			end
		endcase

		// pins follow the next state so every output comes from a flop
		next_area = next_s.req.addr[`EBI_AREA_MSB:`EBI_AREA_LSB];
		next_dram = dram_area3_i && (next_area == `EBI_DRAM_AREA);
		next_s.ready          = (next_s.state == ebi_pkg::ST_IDLE);
		next_s.pins.addr      = next_s.req.addr; // R1
		next_s.pins.dout      = next_s.req.wdata;
		next_s.pins.area_n    = `EBI_AREA_IDLE;
		next_s.pins.addr_strobe_n   = 1'b1;
		next_s.pins.rd_n            = 1'b1;
		next_s.pins.upper_write_n   = 1'b1;
		next_s.pins.lower_write_n   = 1'b1;
		next_s.pins.refresh_cycle_n = 1'b1;
		next_s.pins.grant_n   = 1'b1;
		next_s.pins.bus_oe_b  = 1'b0;
		next_s.pins.data_oe_b = 1'b1;
		case (next_s.state)
			ebi_pkg::ST_ADDR, ebi_pkg::ST_STROBE: begin
				next_s.pins.area_n[next_area] = 1'b0; // R3 R12
				next_s.pins.addr_strobe_n     = 1'b0; // R4
				next_s.pins.data_oe_b         = !next_s.req.write; // R2
				if (next_s.state == ebi_pkg::ST_STROBE) begin
					if (next_dram && dual_cas_i) begin
						next_s.pins.rd_n = !next_s.req.write; // R14
						next_s.pins.upper_write_n = !next_s.req.upper; // R15
						next_s.pins.lower_write_n = !next_s.req.lower; // R16
					end else begin
						// R13: dual WE DRAM takes the read strobe as CAS
						next_s.pins.rd_n = next_s.req.write && !next_dram; // R5 R13
						next_s.pins.upper_write_n = !(next_s.req.write && next_s.req.upper); // R6 R15
						next_s.pins.lower_write_n = !(next_s.req.write && next_s.req.lower); // R7 R16
					end
				end
			end
			ebi_pkg::ST_REF_CAS, ebi_pkg::ST_REF_RAS: begin
				// CAS before RAS refresh, no address needed
				next_s.pins.refresh_cycle_n = 1'b0; // R11
				if (dual_cas_i) begin
					next_s.pins.upper_write_n = 1'b0; // R15
					next_s.pins.lower_write_n = 1'b0; // R16
				end else begin
					next_s.pins.rd_n = 1'b0; // R13
				end
				if (next_s.state == ebi_pkg::ST_REF_RAS) begin
					next_s.pins.area_n[`EBI_DRAM_AREA] = 1'b0; // R12
				end
			end
			ebi_pkg::ST_HELD: begin
				next_s.pins.bus_oe_b = 1'b1; // R17
				next_s.pins.grant_n  = 1'b0; // R10
			end
			default: begin
			end
		endcase
	end

	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			s                <= '0;
			s.state          <= ebi_pkg::ST_IDLE;
			s.req.addr       <= `EBI_ADDR_RST;
			s.pins.area_n    <= `EBI_AREA_IDLE;
			s.pins.addr_strobe_n   <= 1'b1;
			s.pins.rd_n            <= 1'b1;
			s.pins.upper_write_n   <= 1'b1;
			s.pins.lower_write_n   <= 1'b1;
			s.pins.refresh_cycle_n <= 1'b1;
			s.pins.grant_n   <= 1'b1;
			s.pins.data_oe_b <= 1'b1;
			s.rdata          <= `EBI_DATA_RST;
		end else begin
			s <= next_s;
		end
	end

	assign ready_o           = s.ready;
	assign done_o            = s.done;
	assign rdata_o           = s.rdata;
	assign ref_ack_o         = s.ref_ack;
	assign addr_o            = s.pins.addr;
	assign data_o            = s.pins.dout;
	assign data_oe_b_o       = s.pins.data_oe_b;
	assign area_sel_n_o      = s.pins.area_n;
	assign addr_strobe_n_o   = s.pins.addr_strobe_n;
	assign read_n_o          = s.pins.rd_n;
	assign upper_write_n_o   = s.pins.upper_write_n;
	assign lower_write_n_o   = s.pins.lower_write_n;
	assign bus_oe_b_o        = s.pins.bus_oe_b;
	assign bus_grant_n_o     = s.pins.grant_n;
	assign refresh_cycle_n_o = s.pins.refresh_cycle_n;

	logic s_dram;
	assign s_dram = dram_area3_i && (s.req.addr[`EBI_AREA_MSB:`EBI_AREA_LSB] == `EBI_DRAM_AREA);

	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!rst_b_i);

	a_addr_held: assert property ( // R1
		(!addr_strobe_n_o && !$fell(addr_strobe_n_o)) |-> $stable(addr_o))
		else $error("address moved under the strobe");
	a_data_dir: assert property ( // R2
		!data_oe_b_o |-> (s.req.write && !addr_strobe_n_o))
		else $error("data driven outside a write");
	a_one_area: assert property ( // R3
		$countones(~area_sel_n_o) <= 1)
		else $error("more than one area selected");
	a_read_timing: assert property ( // R5
		(req_valid_i && ready_o && bus_hold_request_n_i && !refresh_req_i && !req_i.write
		 && !dram_area3_i) |=> !addr_strobe_n_o ##1 (!read_n_o && !addr_strobe_n_o))
		else $error("read strobe not low two cycles after request");
	a_upper_data: assert property ( // R6
		(!upper_write_n_o && refresh_cycle_n_o && !(s_dram && dual_cas_i)) |-> !data_oe_b_o)
		else $error("upper write without driven data");
	a_lower_data: assert property ( // R7
		(!lower_write_n_o && refresh_cycle_n_o && !(s_dram && dual_cas_i)) |-> !data_oe_b_o)
		else $error("lower write without driven data");
	a_wait_stretch: assert property ( // R8
		(s.state == ebi_pkg::ST_STROBE && !wait_n_i) |=> (s.state == ebi_pkg::ST_STROBE && !done_o))
		else $error("wait did not stretch the cycle");
	a_grant_take: assert property ( // R10
		(s.state == ebi_pkg::ST_IDLE && !bus_hold_request_n_i) |=> !bus_grant_n_o)
		else $error("grant late");
	a_refresh_seq: assert property ( // R11
		$fell(refresh_cycle_n_o) |-> area_sel_n_o[`EBI_DRAM_AREA]
		##1 (!area_sel_n_o[`EBI_DRAM_AREA] && !refresh_cycle_n_o)
		##1 refresh_cycle_n_o)
		else $error("refresh sequence wrong");
	a_cas_dual_we: assert property ( // R13
		(s.state == ebi_pkg::ST_STROBE && s_dram && !dual_cas_i) |-> !read_n_o)
		else $error("column strobe missing");
	a_grant_float: assert property ( // R17
		!bus_grant_n_o |-> (bus_oe_b_o && data_oe_b_o && addr_strobe_n_o))
		else $error("bus driven while granted");

endmodule // ebi_pin_if

`default_nettype wire

// *** ebi_far_mem.sv ***
/* Far-side memory model for the external bus pins.
   Assumes the bench feeds it the device pins and a wait-state count. */
`default_nettype none
module ebi_far_mem (
	input  wire logic        clk_i,   // core clock
	input  wire logic [23:0] addr_i,  // address pins
	input  wire logic [7:0]  sel_n_i, // area selects
	input  wire logic [2:0]  stb_n_i, // read, upper, lower strobes
	input  wire logic        oe_b_i,  // device data enable
	input  wire logic [1:0]  waits_i, // wait states to ask for
	output logic [15:0]      data_o,  // data towards the device
	output logic             wait_n_o // wait request
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [15:0] last;
	logic [1:0]  cnt;
	// released bus shows the inverse of its last value, never a stale copy
	assign data_o = (oe_b_i && !(&sel_n_i)) ? {addr_i[7:0], ~addr_i[7:0]} : ~last;
	assign wait_n_o = !(!(&stb_n_i) && cnt < waits_i);
	always_ff @(posedge clk_i) begin
		last <= data_o;
		cnt <= (&stb_n_i) ? 2'h0 : cnt + 2'h1;
	end
endmodule // ebi_far_mem
`default_nettype wire

// *** external_bus_pin_interface_bench.sv ***
/* Self-checking bench of the external bus pin interface.
   Assumes ebi_pkg, ebi_pin_if and ebi_far_mem are compiled first. */
`default_nettype none
module external_bus_pin_interface_bench;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct packed {
		logic [2:0]  wul;
		logic [23:0] a;
		logic [15:0] d;
		logic [1:0]  wt;
		logic [1:0]  cfg;
		logic [7:0]  sel;
		logic [3:0]  stb;
	} row_s;
	localparam row_s rows [7] = '{
		{3'b011, 24'h000010, 16'h0000, 2'h0, 2'b00, 8'hfe, 4'h3},
		{3'b110, 24'ha00004, 16'hbeef, 2'h2, 2'b00, 8'hdf, 4'h5},
		{3'b101, 24'he00002, 16'h5a3c, 2'h1, 2'b00, 8'h7f, 4'h6},
		{3'b011, 24'h600008, 16'h0000, 2'h1, 2'b10, 8'hf7, 4'h3},
		{3'b111, 24'h60000a, 16'h1234, 2'h0, 2'b10, 8'hf7, 4'h0},
		{3'b011, 24'h60000c, 16'h0000, 2'h0, 2'b11, 8'hf7, 4'h4},
		{3'b110, 24'h60000e, 16'hc3a5, 2'h0, 2'b11, 8'hf7, 4'h1}};
	logic clk = 0, rst_b = 0, valid = 0, rfq = 0, dram = 0, dcas = 0, hold_n = 1;
	logic [1:0] waits = 2'h0;
	ebi_pkg::bus_req_s req = '0;
	logic [15:0] din, rdata, dout;
	logic [23:0] addr;
	logic [7:0]  sel;
	logic rdy, done, ack, doe, aoe, astb_n, rd_n, hi_wr_n, lo_wr_n, gnt_n, rf_n, wait_n;
	int mismatches = 0, samples_checked = 0;
	always #50 clk = ~clk;
	ebi_pin_if u_dut (.core_clk_i(clk), .rst_b_i(rst_b), .req_valid_i(valid), .req_i(req),
		.refresh_req_i(rfq), .dram_area3_i(dram), .dual_cas_i(dcas), .ready_o(rdy),
		.done_o(done), .rdata_o(rdata), .ref_ack_o(ack), .addr_o(addr), .data_o(dout),
		.data_oe_b_o(doe), .data_i(din), .area_sel_n_o(sel), .addr_strobe_n_o(astb_n),
		.read_n_o(rd_n), .upper_write_n_o(hi_wr_n), .lower_write_n_o(lo_wr_n), .bus_oe_b_o(aoe),
		.wait_n_i(wait_n), .bus_hold_request_n_i(hold_n), .bus_grant_n_o(gnt_n),
		.refresh_cycle_n_o(rf_n));
	ebi_far_mem u_mem (.clk_i(clk), .addr_i(addr), .sel_n_i(sel),
		.stb_n_i({rd_n, hi_wr_n, lo_wr_n}),
		.oe_b_i(doe), .waits_i(waits), .data_o(din), .wait_n_o(wait_n));
	task automatic test_done;
		$display("checked %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// bounded wait on one flag; running out ends the run
	task automatic wait_for(ref logic f, input logic v);
		// look off the launching edge so a flag updated there is settled
		@(negedge clk);
		for (int i = 0; i < 20 && f !== v; i++)
			@(negedge clk);
		if (f !== v) begin
			mismatches++;
			test_done();
		end
	endtask
	task automatic access(input row_s r, input logic hm);
		logic [3:0]  stb;
		logic [7:0]  s;
		logic [15:0] wd, m;
		logic        g;
		logic [23:0] ad;
		int          n;
		stb = 4'hf;
		ad = 24'h0;
		s = 8'hff;
		g = 1'b1;
		wd = 16'h0;
		n = 0;
		m = {{8{r.wul[1]}}, {8{r.wul[0]}}};
		@(posedge clk);
		{dram, dcas} <= r.cfg;
		waits <= r.wt;
		wait_for(rdy, 1'b1);
		@(posedge clk);
		valid <= 1'b1;
		req <= {r.wul, r.a, r.d};
		@(posedge clk);
		valid <= 1'b0;
		if (hm)
			hold_n <= 1'b0;
		while (done !== 1'b1 && n < 12) begin
			@(negedge clk);
			n++;
			stb &= {astb_n, rd_n, hi_wr_n, lo_wr_n};
			if (astb_n === 1'b0)
				ad = addr;
			s &= sel;
			g &= gnt_n;
			if (doe === 1'b0 && (hi_wr_n & lo_wr_n) === 1'b0)
				wd = dout;
		end
		chk("cycles", n, 3 + r.wt);
		chk("strobes", stb, r.stb);
		chk("selects", s, r.sel);
		chk("address", ad, r.a);
		chk("grant during access", g, 1);
		if (r.wul[2])
			chk("wdata", wd & m, r.d & m);
		else
			chk("rdata", rdata, {r.a[7:0], ~r.a[7:0]});
	endtask
	initial begin
		logic [7:0] s;
		logic       g;
		logic [2:0] c;
		repeat (10) @(posedge clk);
		rst_b <= 1'b1;
		foreach (rows[i]) begin
			access(rows[i], 1'b0);
			$display("test row %0d done", i);
		end
		// hold raised at the take edge: access finishes, then the bus is handed over
		access(rows[0], 1'b1);
		wait_for(gnt_n, 1'b0);
		chk("released pins", {aoe, doe}, 2'b11);
		@(posedge clk);
		hold_n <= 1'b1;
		wait_for(gnt_n, 1'b1);
		$display("test hold done");
		// dram refresh on area 3, two-WE then two-CAS
		for (int k = 0; k < 2; k++) begin
			@(posedge clk);
			rfq <= 1'b1;
			dram <= 1'b1;
			dcas <= k[0];
			waits <= 2'h0;
			s = 8'hff;
			g = 1'b1;
			c = 3'h7;
			for (int i = 0; i < 10 && ack !== 1'b1; i++) begin
				@(negedge clk);
				s &= sel;
				g &= rf_n;
				c &= {rd_n, hi_wr_n, lo_wr_n};
			end
			chk("refresh ack", ack, 1);
			chk("refresh flag", g, 0);
			chk("row strobe", s, 8'hf7);
			chk("refresh column strobes", c, (k != 0) ? 3'h4 : 3'h3);
			@(posedge clk);
			rfq <= 1'b0;
		end
		$display("test refresh done");
		// reset in mid-run
		@(posedge clk);
		rst_b <= 1'b0;
		@(negedge clk);
		chk("reset selects", sel, 8'hff);
		chk("reset strobes", {astb_n, rd_n, hi_wr_n, lo_wr_n, gnt_n, rf_n, doe}, 7'h7f);
		chk("reset ready", rdy, 0);
		repeat (2) @(posedge clk);
		rst_b <= 1'b1;
		access(rows[1], 1'b0);
		$display("test reset done");
		test_done();
	end
endmodule // external_bus_pin_interface_bench
`default_nettype wire
